// ### shared/adcr_pkg.sv
// adcr_pkg: constants, bus carriers and state for the converter control block
// assumes a single ahb-lite master and one clock (fosc) for everything
package adcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_IRQ_ENABLE_SECOND  = 8'h9a;
    localparam logic [7:0] IDX_PORT0_ISOLATION    = 8'h9e;
    localparam logic [7:0] IDX_IRQ_REQUEST_SECOND = 8'hbf;
    localparam logic [7:0] IDX_CONVERTER_MODE     = 8'hd2;
    localparam logic [7:0] IDX_RESULT_HIGH        = 8'hd3;
    localparam logic [7:0] IDX_CLOCK_RESULT_LOW   = 8'hd4;
    localparam logic [7:0] IDX_REFERENCE_SELECT   = 8'hd5;
    localparam logic [7:0] IDX_EVENT_STATUS       = 8'he0;
    localparam logic [7:0] IDX_EVENT_MASK         = 8'he1;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_CONV_ENABLE = 7;
    localparam int BIT_CONV_START  = 6;
    localparam int BIT_CONV_EOC    = 5;
    localparam int BIT_CHAN_LSB    = 0;
    localparam int BIT_GATE        = 6;
    localparam int BIT_CKSEL_LSB   = 4;
    localparam int BIT_REF_LSB     = 0;
    localparam int BIT_ISO_LSB     = 0;
    localparam int BIT_IRQ_ENABLE  = 0;
    localparam int BIT_IRQ_FLAG    = 0;
    localparam int EVT_DONE        = 0;
    localparam int EVT_REFUSED     = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0]  RST_CHANNEL = 4'h0;
    localparam logic [1:0]  RST_CKSEL   = 2'h0;
    localparam logic [2:0]  RST_REF     = 3'h0;
    localparam logic [5:0]  RST_ISO     = 6'h00;
    localparam logic [11:0] RST_RESULT  = 12'h000;
    localparam logic [1:0]  RST_MASK    = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // converter clock selection and conversion length
    localparam logic [1:0] CKSEL_DIV16 = 2'h0;
    localparam logic [1:0] CKSEL_DIV8  = 2'h1;
    localparam logic [1:0] CKSEL_DIV1  = 2'h2;
    localparam logic [1:0] CKSEL_DIV2  = 2'h3;
    localparam int CONV_PERIODS = 16;  // periods of converter clock / 4
    localparam int CONV_PRESCALE = 4;

    // reference selection codes
    localparam logic [2:0] REF_2V0      = 3'h0;
    localparam logic [2:0] REF_3V0      = 3'h1;
    localparam logic [2:0] REF_4V0      = 3'h2;
    localparam logic [2:0] REF_SUP_2V0  = 3'h4;
    localparam logic [2:0] REF_SUP_3V0  = 3'h5;
    localparam logic [2:0] REF_SUP_4V0  = 3'h6;
    // channel codes
    localparam logic [3:0] CHAN_LAST_PIN = 4'h5;
    localparam logic [3:0] CHAN_SUPPLY   = 4'h6;
    localparam logic [3:0] CHAN_GROUND   = 4'h7;
    localparam logic [3:0] CHAN_FIXED    = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite carriers
    typedef struct packed {
        logic        hsel;
        logic [9:0]  haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } adcr_ahb_req_type;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } adcr_ahb_resp_type;

    // settings that face the analog macro and port 0
    typedef struct packed {
        logic       conv_enable;
        logic       converting;
        logic       global_channel_gate;
        logic [1:0] converter_clock_select;
        logic [3:0] input_channel_field;
        logic [2:0] reference_select_field;
        logic       ref_from_supply;
        logic       channel_reserved;
        logic [5:0] port0_isolation_bits;
    } adcr_analog_type;

    // fosc cycles of one converter-clock/4 period for a selection
    function automatic logic [6:0] adcr_quarter_cycles(input logic [1:0] sel);
        logic [6:0] div;
        div = 7'h10;
        unique case (sel)
            CKSEL_DIV16: div = 7'h10;
            CKSEL_DIV8:  div = 7'h08;
            CKSEL_DIV1:  div = 7'h01;
            CKSEL_DIV2:  div = 7'h02;
        endcase
        return 7'(div * 7'(CONV_PRESCALE));
    endfunction

endpackage

// ### src/adcr_conv_timer.sv
// adcr_conv_timer: paces one conversion from the converter clock selection
// assumes launch is a one-cycle pulse and is not given while busy
`timescale 1ns/100ps
`default_nettype none

module adcr_conv_timer
    import adcr_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // control
    input  wire logic       launch,
    input  wire logic [1:0] clk_sel,
    // progress
    output logic            busy,
    output logic            done
);
    typedef struct packed {
        logic       busy;
        logic [6:0] quarter;   // fosc cycles left in this quarter period
        logic [4:0] period;    // quarter periods left
        logic [6:0] reload;
    } adcr_timer_type;

    adcr_timer_type s;
    adcr_timer_type next_s;

    ////////////////////////////////////////////////////////////////////////
    // divider: fosc down to converter clock / 4, sixteen periods in all
    always_comb
    begin
        next_s = s;
        if (launch)
        begin
            next_s.busy    = 1'b1;
            next_s.reload  = adcr_quarter_cycles(clk_sel);
            next_s.quarter = 7'(adcr_quarter_cycles(clk_sel) - 7'h01);
            next_s.period  = 5'(CONV_PERIODS - 1);
        end
        else if (s.busy)
        begin
            if (s.quarter != 7'h00)
                next_s.quarter = 7'(s.quarter - 7'h01);
            else if (s.period != 5'h00)
            begin
                next_s.quarter = 7'(s.reload - 7'h01);
                next_s.period  = 5'(s.period - 5'h01);
            end
            else
                next_s.busy = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign busy = s.busy;
    assign done = s.busy && s.quarter == 7'h00 && s.period == 5'h00;

endmodule
`default_nettype wire

// ### src/adcr_control.sv
// adcr_control: register file and sequencing of the 12-bit converter
// assumes one ahb-lite master, fosc as ref_clk, result from the analog macro
`timescale 1ns/100ps
`default_nettype none

module adcr_control
    import adcr_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // register bus
    input  wire adcr_pkg::adcr_ahb_req_type  bus_req,
    output adcr_pkg::adcr_ahb_resp_type      bus_resp,
    // analog macro
    input  wire logic [11:0]       analog_result,
    output adcr_pkg::adcr_analog_type        analog_ctl,
    // cpu interrupt controller
    input  wire logic              isr_ack,
    output logic                   converter_irq_req,
    output logic                   irq
);
    import adcr_pkg::*;

    typedef struct packed {
        logic        conv_enable;
        logic        start;
        logic        eoc;
        logic [3:0]  channel;
        logic [11:0] result;
        logic        gate;
        logic [1:0]  clk_sel;
        logic [2:0]  ref_sel;
        logic [5:0]  iso;
        logic        irq_en;
        logic        irq_flag;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        ap_valid;
        logic        ap_write;
        logic [7:0]  ap_index;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        irq;
        logic        cpu_irq;
        logic        converting;
        logic        ref_supply;
        logic        chan_reserved;
    } adcr_ctl_type;

    adcr_ctl_type s;
    adcr_ctl_type next_s;
    logic         launch;
    logic         conv_busy;
    logic         conv_done;
    logic         accept;
    logic         wr_hit;
    logic [7:0]   wdat;
    logic [1:0]   events;
    logic [7:0]   rd;

    ////////////////////////////////////////////////////////////////////////
    // conversion pacing
    adcr_conv_timer u_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .launch  (launch),
        .clk_sel (s.clk_sel),
        .busy    (conv_busy),
        .done    (conv_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus qualifiers
    assign accept = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;
    assign wr_hit = s.ap_valid && s.ap_write;
    assign wdat   = bus_req.hwdata[7:0];

    // next state: writes, then acknowledge, then completion so sets win
    always_comb
    begin
        next_s           = s;
        launch           = 1'b0;
        events           = 2'h0;
        rd               = 8'h00;
        next_s.hreadyout = 1'b1;
        // data phase of a write
        if (wr_hit)
        begin
            unique case (s.ap_index)
                IDX_CONVERTER_MODE:
                begin
                    next_s.conv_enable = wdat[BIT_CONV_ENABLE];
                    next_s.channel     = wdat[BIT_CHAN_LSB +: 4];
                    if (!wdat[BIT_CONV_EOC])
                        next_s.eoc = 1'b0;
                    if (wdat[BIT_CONV_START] && !s.start)
                    begin
                        if (wdat[BIT_CONV_ENABLE])
                            launch = 1'b1;
                        else
                            events[EVT_REFUSED] = 1'b1;
                    end
                end
                IDX_CLOCK_RESULT_LOW:
                begin
                    next_s.gate    = wdat[BIT_GATE];
                    next_s.clk_sel = wdat[BIT_CKSEL_LSB +: 2];
                end
                IDX_REFERENCE_SELECT:
                    next_s.ref_sel = wdat[BIT_REF_LSB +: 3];
                IDX_PORT0_ISOLATION:
                    next_s.iso = wdat[BIT_ISO_LSB +: 6];
                IDX_IRQ_ENABLE_SECOND:
                    next_s.irq_en = wdat[BIT_IRQ_ENABLE];
                IDX_IRQ_REQUEST_SECOND:
                    next_s.irq_flag = wdat[BIT_IRQ_FLAG];
                IDX_EVENT_MASK:
                    next_s.mask = wdat[1:0];
                default:
                    next_s.mask = s.mask;
            endcase
        end
        // a vector to the handler drops the request
        if (isr_ack)
            next_s.irq_flag = 1'b0;
        // start of a conversion
        if (launch)
        begin
            next_s.start = 1'b1;
            next_s.eoc   = 1'b0;
        end
        // end of a conversion: one edge for all
        if (conv_done)
        begin
            next_s.start    = 1'b0;
            next_s.eoc      = 1'b1;
            next_s.result   = analog_result;
            next_s.irq_flag = 1'b1;
            events[EVT_DONE] = 1'b1;
        end
        // read mux sees this cycle's updates; status shows its old value
        unique case (bus_req.haddr[9:2])
            IDX_CONVERTER_MODE:
                rd = {next_s.conv_enable, next_s.start, next_s.eoc, 1'b0,
                      next_s.channel};
            IDX_RESULT_HIGH:      rd = next_s.result[11:4];
            IDX_CLOCK_RESULT_LOW:
                rd = {1'b0, next_s.gate, next_s.clk_sel,
                      next_s.result[3:0]};
            IDX_REFERENCE_SELECT: rd = {5'h00, next_s.ref_sel};
            IDX_PORT0_ISOLATION:  rd = {2'h0, next_s.iso};
            IDX_IRQ_ENABLE_SECOND: rd = {7'h00, next_s.irq_en};
            IDX_IRQ_REQUEST_SECOND: rd = {7'h00, next_s.irq_flag};
            IDX_EVENT_STATUS:     rd = {6'h00, s.status};
            IDX_EVENT_MASK:       rd = {6'h00, next_s.mask};
            default:              rd = 8'h00;
        endcase
        // sticky status, cleared by a read, new events kept
        if (accept && !bus_req.hwrite
            && bus_req.haddr[9:2] == IDX_EVENT_STATUS)
            next_s.status = events;
        else
            next_s.status = s.status | events;
        // address phase
        next_s.ap_valid = accept;
        next_s.ap_write = accept && bus_req.hwrite;
        next_s.ap_index = bus_req.haddr[9:2];
        if (accept && !bus_req.hwrite)
            next_s.hrdata = {24'h000000, rd};
        // outputs
        next_s.irq        = |(next_s.status & next_s.mask);
        next_s.cpu_irq    = next_s.irq_flag && next_s.irq_en;
        next_s.converting = next_s.start;
        next_s.ref_supply = next_s.ref_sel[2];
        next_s.chan_reserved = next_s.channel > CHAN_FIXED;
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s           <= '0;
            s.channel   <= RST_CHANNEL;
            s.result    <= RST_RESULT;
            s.clk_sel   <= RST_CKSEL;
            s.ref_sel   <= RST_REF;
            s.iso       <= RST_ISO;
            s.mask      <= RST_MASK;
            s.hreadyout <= 1'b1;
        end
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops except hresp, which is tied low
    assign bus_resp.hrdata    = s.hrdata;
    assign bus_resp.hreadyout = s.hreadyout;
    assign bus_resp.hresp     = 1'b0;
    assign analog_ctl.conv_enable            = s.conv_enable;
    assign analog_ctl.converting             = s.converting;
    assign analog_ctl.global_channel_gate    = s.gate;
    assign analog_ctl.converter_clock_select = s.clk_sel;
    assign analog_ctl.input_channel_field    = s.channel;
    assign analog_ctl.reference_select_field = s.ref_sel;
    assign analog_ctl.ref_from_supply        = s.ref_supply;
    assign analog_ctl.channel_reserved       = s.chan_reserved;
    assign analog_ctl.port0_isolation_bits   = s.iso;
    assign converter_irq_req = s.cpu_irq;
    assign irq               = s.irq;

    ////////////////////////////////////////////////////////////////////////
    // checking
    default clocking chk_clk @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // helper: cycles since launch and the length expected for it
    logic [10:0] chk_count;
    logic [10:0] chk_expect;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            chk_count  <= 11'h000;
            chk_expect <= 11'h000;
        end
        else if (launch)
        begin
            // counts edges after the launch edge, so it equals n at the end
            chk_count  <= 11'h000;
            chk_expect <= 11'(adcr_quarter_cycles(s.clk_sel) * 11'(CONV_PERIODS));
        end
        else if (s.start)
            chk_count <= 11'(chk_count + 11'h001);
    end

    sequence seq_done_edge;
        conv_done;
    endsequence
    sequence seq_all_updated;
        s.eoc && s.irq_flag && !s.start;
    endsequence

    conv_length_a: assert property ($rose(s.eoc) |-> chk_count == chk_expect)
        else $error("conversion length does not match clock selection");
    done_update_a: assert property (seq_done_edge |=> seq_all_updated)
        else $error("end status, flag and start did not change together");
    result_load_a: assert property (conv_done |=> s.result == $past(analog_result))
        else $error("result not loaded at end of conversion");
    launch_state_a: assert property (launch |=> s.start && !s.eoc ##1 !s.eoc)
        else $error("end status set while converting");
    flag_ack_a: assert property (isr_ack && !conv_done |=> !s.irq_flag)
        else $error("request flag not cleared on vectoring");
    irq_masked_a: assert property (!s.irq_en [*2] |-> !s.cpu_irq)
        else $error("converter request raised while disabled");
    gate_write_a: assert property (wr_hit && s.ap_index == IDX_CLOCK_RESULT_LOW
        |=> s.gate == $past(wdat[BIT_GATE])
            && analog_ctl.global_channel_gate == s.gate)
        else $error("channel gate write not applied");
    iso_write_a: assert property (wr_hit && s.ap_index == IDX_PORT0_ISOLATION
        |=> analog_ctl.port0_isolation_bits == $past(wdat[5:0]))
        else $error("isolation write not applied");
    result_read_a: assert property (accept && !bus_req.hwrite
        && bus_req.haddr[9:2] == IDX_RESULT_HIGH
        |=> bus_resp.hrdata == {24'h000000, s.result[11:4]})
        else $error("result high byte read wrong");

endmodule
`default_nettype wire

// ### sim/adcr_control_bench.sv
// adcr_control_bench: self-checking bench for the converter control block
// assumes zero-wait ahb-lite slave and the one fosc clock of the design
`timescale 1ns/100ps
`default_nettype none

module adcr_control_bench;
    import adcr_pkg::*;

    logic              ref_clk;
    logic              rst;
    adcr_ahb_req_type  bus_req;
    adcr_ahb_resp_type bus_resp;
    logic [11:0]       analog_result;
    adcr_analog_type   analog_ctl;
    logic              isr_ack;
    logic              converter_irq_req;
    logic              irq;
    logic              rd_dphase;
    logic [31:0]       cyc;
    logic [31:0]       exp_q[$];
    int                err_total;
    int                cmp_count;

    adcr_control DUT (
        .ref_clk           (ref_clk),
        .rst               (rst),
        .bus_req           (bus_req),
        .bus_resp          (bus_resp),
        .analog_result     (analog_result),
        .analog_ctl        (analog_ctl),
        .isr_ack           (isr_ack),
        .converter_irq_req (converter_irq_req),
        .irq               (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock, cycle count and time-zero values
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 32'h1;
    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        cyc = 32'h0;
        bus_req = '0;
        bus_req.hready = 1'b1;
        bus_req.hsize = 3'h2;
        analog_result = 12'h000;
        isr_ack = 1'b0;
        rd_dphase = 1'b0;
        err_total = 0;
        cmp_count = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // comparison, verdict and bus cycles
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one single word transfer; a read notes its expected byte
    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [7:0] wd, input logic [7:0] ex);
        @(posedge ref_clk);
        bus_req.hsel   <= 1'b1;
        bus_req.htrans <= 2'b10;
        bus_req.haddr  <= {idx, 2'b00};
        bus_req.hwrite <= wr;
        @(posedge ref_clk);
        while (bus_resp.hreadyout !== 1'b1) @(posedge ref_clk);
        bus_req.hsel   <= 1'b0;
        bus_req.htrans <= 2'b00;
        bus_req.hwdata <= {24'h0, wd};
        rd_dphase      <= !wr;
        if (!wr)
            exp_q.push_back({24'h0, ex});
        @(posedge ref_clk);
        while (bus_resp.hreadyout !== 1'b1) @(posedge ref_clk);
        rd_dphase      <= 1'b0;
        // leave the edge so callers see settled outputs
        #1;
    endtask

    // read data taken at the data-phase edge against the oldest note
    always @(posedge ref_clk)
    begin
        if (rd_dphase && bus_resp.hreadyout === 1'b1 && exp_q.size() > 0)
        begin
            check(bus_resp.hrdata, exp_q.pop_front());
            check(32'(bus_resp.hresp), 32'h0);
        end
    end

    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin : main_seq
        logic [7:0]  idx_tab[10];
        logic [2:0]  ref_tab[6];
        logic [3:0]  chan_tab[4];
        logic [7:0]  w;
        logic [11:0] res;
        logic [31:0] t0;
        logic [31:0] n;
        logic [1:0]  sel;
        logic        ien;
        logic        msk;
        idx_tab = '{IDX_IRQ_ENABLE_SECOND, IDX_PORT0_ISOLATION,
                    IDX_IRQ_REQUEST_SECOND, IDX_CONVERTER_MODE,
                    IDX_RESULT_HIGH, IDX_CLOCK_RESULT_LOW,
                    IDX_REFERENCE_SELECT, IDX_EVENT_STATUS,
                    IDX_EVENT_MASK, 8'h10};
        ref_tab = '{REF_2V0, REF_3V0, REF_4V0,
                    REF_SUP_2V0, REF_SUP_3V0, REF_SUP_4V0};
        chan_tab = '{CHAN_LAST_PIN, CHAN_SUPPLY, CHAN_GROUND, CHAN_FIXED};
        void'($urandom(32'hf363775d));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;

        // every register and an unmapped word read zero after reset
        foreach (idx_tab[i])
            bus(idx_tab[i], 1'b0, 8'h00, 8'h00);
        $display("test reset_values done");

        // random settings land in their fields, reserved bits read 0
        w = 8'($urandom());
        bus(IDX_PORT0_ISOLATION, 1'b1, w, 8'h00);
        bus(IDX_PORT0_ISOLATION, 1'b0, 8'h00, w & 8'h3f);
        check(32'(analog_ctl.port0_isolation_bits), 32'(w[5:0]));
        w = 8'($urandom());
        bus(IDX_CLOCK_RESULT_LOW, 1'b1, w, 8'h00);
        bus(IDX_CLOCK_RESULT_LOW, 1'b0, 8'h00, w & 8'h70);
        check(32'(analog_ctl.global_channel_gate), 32'(w[6]));
        check(32'(analog_ctl.converter_clock_select), 32'(w[5:4]));
        bus(IDX_RESULT_HIGH, 1'b1, 8'hff, 8'h00);
        bus(IDX_RESULT_HIGH, 1'b0, 8'h00, 8'h00);
        foreach (ref_tab[i])
        begin
            bus(IDX_REFERENCE_SELECT, 1'b1, {5'h0, ref_tab[i]}, 8'h00);
            bus(IDX_REFERENCE_SELECT, 1'b0, 8'h00, {5'h0, ref_tab[i]});
            check(32'(analog_ctl.ref_from_supply), 32'(ref_tab[i][2]));
            check(32'(analog_ctl.reference_select_field), 32'(ref_tab[i]));
        end
        bus(IDX_CONVERTER_MODE, 1'b1, 8'h89, 8'h00);
        check(32'(analog_ctl.channel_reserved), 32'h1);
        check(32'(analog_ctl.conv_enable), 32'h1);
        check(32'(analog_ctl.input_channel_field), 32'h9);
        $display("test register_fields done");

        // a start without the enable bit is refused and reported
        bus(IDX_CONVERTER_MODE, 1'b1, 8'h40, 8'h00);
        check(32'(analog_ctl.converting), 32'h0);
        bus(IDX_EVENT_STATUS, 1'b0, 8'h00, 8'h02);
        bus(IDX_EVENT_STATUS, 1'b0, 8'h00, 8'h00);
        $display("test refused_start done");

        // one conversion per clock selection, with masking varied
        for (int i = 0; i < 4; i++)
        begin
            sel = 2'(i);
            ien = (i != 2);
            msk = (i != 3);
            res = 12'($urandom());
            analog_result <= res;
            bus(IDX_REFERENCE_SELECT, 1'b1, {5'h0, REF_SUP_3V0}, 8'h00);
            bus(IDX_CLOCK_RESULT_LOW, 1'b1, {2'b01, sel, 4'h0}, 8'h00);
            bus(IDX_IRQ_ENABLE_SECOND, 1'b1, {7'h0, ien}, 8'h00);
            bus(IDX_EVENT_MASK, 1'b1, {7'h0, msk}, 8'h00);
            bus(IDX_CONVERTER_MODE, 1'b1, {4'hc, chan_tab[i]}, 8'h00);
            #1;
            t0 = cyc;
            bus(IDX_CONVERTER_MODE, 1'b0, 8'h00, {4'hc, chan_tab[i]});
            bus(IDX_CONVERTER_MODE, 1'b1, {4'hc, chan_tab[i]}, 8'h00);
            #1;
            while (analog_ctl.converting === 1'b1 && cyc - t0 < 32'd3000)
            begin
                @(posedge ref_clk);
                #1;
            end
            n = cyc - t0;
            check(n, 32'(64 * (sel == 2'h0 ? 16 : sel == 2'h1 ? 8 :
                               sel == 2'h2 ? 1 : 2)));
            @(posedge ref_clk);
            #1;
            check(32'(converter_irq_req), 32'(ien));
            check(32'(irq), 32'(msk));
            bus(IDX_IRQ_REQUEST_SECOND, 1'b0, 8'h00, 8'h01);
            bus(IDX_RESULT_HIGH, 1'b0, 8'h00, res[11:4]);
            bus(IDX_CLOCK_RESULT_LOW, 1'b0, 8'h00,
                {2'b01, sel, res[3:0]});
            bus(IDX_CONVERTER_MODE, 1'b0, 8'h00, {4'ha, chan_tab[i]});
            bus(IDX_EVENT_STATUS, 1'b0, 8'h00, 8'h01);
            bus(IDX_EVENT_STATUS, 1'b0, 8'h00, 8'h00);
            repeat (2) @(posedge ref_clk);
            #1;
            check(32'(irq), 32'h0);
            isr_ack <= 1'b1;
            @(posedge ref_clk);
            isr_ack <= 1'b0;
            bus(IDX_IRQ_REQUEST_SECOND, 1'b0, 8'h00, 8'h00);
            bus(IDX_CONVERTER_MODE, 1'b1, {4'h8, chan_tab[i]}, 8'h00);
            bus(IDX_CONVERTER_MODE, 1'b0, 8'h00, {4'h8, chan_tab[i]});
            $display("test conversion %0d done", i);
        end
        repeat (4) @(posedge ref_clk);
        print_verdict();
    end

endmodule

`default_nettype wire
